// file: qdr_defs.vh
// Offsets, field positions, reset values and timing counts of the quadrature decoder
`ifndef QDR_DEFS_VH
`define QDR_DEFS_VH
`define QDR_OFS_START      12'h000
`define QDR_OFS_STOP       12'h004
`define QDR_OFS_SNAPCLR    12'h008
`define QDR_OFS_SHORTCUT   12'h200
`define QDR_OFS_INTEN      12'h300
`define QDR_OFS_INTSTAT    12'h304
`define QDR_OFS_INTCLR     12'h308
`define QDR_OFS_ENABLE     12'h500
`define QDR_OFS_LEDLEVEL   12'h504
`define QDR_OFS_INTERVAL   12'h508
`define QDR_OFS_STEP       12'h50c
`define QDR_OFS_REPPER     12'h510
`define QDR_OFS_TOTAL      12'h514
`define QDR_OFS_TOTSNAP    12'h518
`define QDR_OFS_LEDPIN     12'h51c
`define QDR_OFS_APIN       12'h520
`define QDR_OFS_BPIN       12'h524
`define QDR_OFS_DEBOUNCE   12'h528
`define QDR_OFS_LEDLEAD    12'h540
`define QDR_OFS_DBLCNT     12'h544
`define QDR_OFS_DBLSNAP    12'h548
`define QDR_PSEL_RESET     32'hffffffff
`define QDR_PSEL_OFF       32'hffffffff
`define QDR_EV_STEPRDY     0
`define QDR_EV_REPORTRDY   1
`define QDR_EV_OVERFLOW    2
`define QDR_SH_REP_SNAP    0
`define QDR_SH_STEP_STOP   1
`define QDR_DBL_MAX        4'hf
`define QDR_BASE_PERIOD_NS 128000
`define QDR_CLK_PERIOD_NS  50
`endif

// file: qdr_encoder_model.sv
// Encoder model that drives the two phase levels
module qdr_encoder_model (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [1:0] move,
	output logic      [1:0] ph
);
	timeunit 1ns;
	timeprecision 1ps;
	// ph is {A, B}; forward order 00, 01, 11, 10
	initial ph = 2'h0;
	always @(posedge clk)
		if (go)
			case (move)
				2'h1: ph <= {ph[0], ~ph[1]};
				2'h2: ph <= {~ph[0], ph[1]};
				2'h3: ph <= ~ph;
				default: ph <= ph;
			endcase
endmodule // qdr_encoder_model

// file: qdr_quad_decoder.v
// Register-level quadrature decoder: sampling, decoding, totals, snapshot and interrupt
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Valid plus or minus one steps update total
// - Double transition bumps separate count instead
// - Total is 32-bit two's complement signed
// - Overflowing step discarded, total kept, event raised
// - Snapshot task clears total after copying
// - Snapshot task copies both counters, zeroes them
// - Phase B select register picks phase pin
// - All ones in phase B select disables
// - Sample pairs compared: +1, -1, 0, 2
//////////////////////////////////////////////////////////////////////////////
//
// The strobed register port and the register offsets were chosen for this implementation.
`include "qdr_defs.vh"
module qdr_quad_decoder #(
	parameter NPINS      = 32,
	parameter BASE_TICKS = `QDR_BASE_PERIOD_NS / `QDR_CLK_PERIOD_NS
) (
	input  wire              clk,
	input  wire              nrst,
	input  wire [11:0]       addr,
	input  wire [31:0]       wdata,
	input  wire              wr,
	input  wire              rd,
	output reg  [31:0]       rdata,
	input  wire [NPINS-1:0]  pins_in,
	output reg               led_out,
	output reg               irq
);

	// One-hot run states
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN  = 2'b10;

	// Software-visible registers and run state
	reg [1:0]  state;
	reg [1:0]  shortcut;
	reg        enable;
	reg        led_pol;
	reg [2:0]  interval;
	reg [2:0]  rep_per;
	reg [31:0] psel_led;
	reg [31:0] psel_a;
	reg [31:0] psel_b;
	reg        debounce;
	reg [8:0]  led_lead;

	// Live counters and their snapshots
	reg [31:0] step;
	reg [31:0] total;
	reg [31:0] total_snap;
	reg [3:0]  dbl_cnt;
	reg [3:0]  dbl_snap;
	reg [2:0]  int_en;
	reg [2:0]  int_stat;
	reg [1:0]  prev_ab;
	reg        have_prev;
	reg [31:0] tick_cnt;
	reg [8:0]  rep_cnt;

	// Pin select: all ones or out of range leaves phase at 0
	function pin_pick;
		input [31:0]      sel;
		input [NPINS-1:0] pins;
		begin
			if (sel == `QDR_PSEL_OFF || sel >= NPINS)
				pin_pick = 1'b0;
			else
				pin_pick = pins[sel[4:0]];
		end
	endfunction

	// Step code from previous and current pair {a,b}
	function [31:0] decode;
		input [1:0] p;
		input [1:0] c;
		begin
			case ({p, c})
				4'b0001, 4'b0111, 4'b1000, 4'b1110:
					decode = 32'h00000001;
				4'b0010, 4'b0100, 4'b1011, 4'b1101:
					decode = 32'hffffffff;
				4'b0011, 4'b0110, 4'b1001, 4'b1100:
					decode = 32'h00000002;
				default:
					decode = 32'h00000000;
			endcase
		end
	endfunction

	// Samples per report: 10, then 40 per code step
	function [8:0] rep_samples;
		input [2:0] code;
		begin
			if (code == 3'h0)
				rep_samples = 9'h00a;
			else
				rep_samples = {4'h0, code, 2'b00} * 9'h00a;
		end
	endfunction

	// Write strobe aimed at one register offset
	function wr_hit;
		input        strobe;
		input [11:0] a;
		input [11:0] ofs;
		begin
			wr_hit = strobe && (a == ofs);
		end
	endfunction

	wire        cur_a    = pin_pick(psel_a, pins_in);
	wire        cur_b    = pin_pick(psel_b, pins_in);
	wire [31:0] period   = BASE_TICKS << interval;
	wire        running  = (state == ST_RUN) && enable;
	wire        sample_now = running && (tick_cnt >= period - 32'h1);
	wire [31:0] new_step = decode(prev_ab, {cur_a, cur_b});
	wire        is_dbl   = have_prev && (new_step == 32'h00000002);
	wire        is_valid = have_prev && (new_step == 32'h00000001 || new_step == 32'hffffffff);
	wire [31:0] sum      = total + new_step;
	wire        ovf      = is_valid && (total[31] == new_step[31]) && (sum[31] != total[31]);
	wire        dbl_ovf  = is_dbl && (dbl_cnt == `QDR_DBL_MAX);
	wire        ev_step  = sample_now;
	wire        rep_hit  = sample_now && (rep_cnt + 9'h001 >= rep_samples(rep_per));
	wire        ev_rep   = rep_hit && ((is_valid && !ovf) ? (sum != 32'h0) : (total != 32'h0));
	wire        ev_ovf   = sample_now && (ovf || dbl_ovf);
	wire        do_start = wr_hit(wr, addr, `QDR_OFS_START);
	wire        do_stop  = wr_hit(wr, addr, `QDR_OFS_STOP) || (ev_step && shortcut[`QDR_SH_STEP_STOP]);
	wire        do_snap  = wr_hit(wr, addr, `QDR_OFS_SNAPCLR) || (ev_rep && shortcut[`QDR_SH_REP_SNAP]);
	wire        do_clr   = wr_hit(wr, addr, `QDR_OFS_INTCLR);
	wire [2:0]  events   = {ev_ovf, ev_rep, ev_step};
	// LED lead window in clock ticks, 20 per microsecond
	wire        led_used   = psel_led != `QDR_PSEL_OFF;
	wire [31:0] lead_ticks = {23'h0, led_lead} * 32'h00000014;
	wire        led_window = (period - tick_cnt) <= lead_ticks;

	//////////////////////////////////////////////////////////////////////////////
	// Run control and sampling timer
	reg [1:0]  next_state;
	reg [31:0] next_tick;
	always @*
	begin
		next_state = state;
		next_tick  = 32'h0;
		case (state)
			ST_IDLE:
			begin
				if (do_start)
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (do_stop || !enable)
					next_state = ST_IDLE;
				next_tick = sample_now ? 32'h0 : tick_cnt + 32'h1;
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk)
	begin
		if (!nrst)
		begin
			state     <= ST_IDLE;
			tick_cnt  <= 32'h0;
			have_prev <= 1'b0;
			prev_ab   <= 2'b00;
			step      <= 32'h0;
			rep_cnt   <= 9'h000;
		end
		else
		begin
			state    <= next_state;
			tick_cnt <= next_tick;
			if (do_start && state == ST_IDLE)
				have_prev <= 1'b0;
			else if (sample_now)
			begin
				prev_ab   <= {cur_a, cur_b};
				have_prev <= 1'b1;
				step      <= have_prev ? new_step : 32'h0;
				rep_cnt   <= rep_hit ? 9'h000 : rep_cnt + 9'h001;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Totals and snapshots; a step landing with the snapshot goes to the snapshot
	reg [31:0] live_total;
	reg [3:0]  live_dbl;
	reg [31:0] next_total;
	reg [3:0]  next_dbl_cnt;
	reg [31:0] next_total_snap;
	reg [3:0]  next_dbl_snap;
	always @*
	begin
		live_total = total;
		live_dbl   = dbl_cnt;
		if (sample_now && is_valid && !ovf)
			live_total = sum;
		if (sample_now && is_dbl && !dbl_ovf)
			live_dbl = dbl_cnt + 4'h1;
		next_total      = live_total;
		next_dbl_cnt    = live_dbl;
		next_total_snap = total_snap;
		next_dbl_snap   = dbl_snap;
		if (do_snap)
		begin
			next_total_snap = live_total;
			next_dbl_snap   = live_dbl;
			next_total      = 32'h0;
			next_dbl_cnt    = 4'h0;
		end
	end

	always @(posedge clk)
	begin
		if (!nrst)
		begin
			total      <= 32'h0;
			dbl_cnt    <= 4'h0;
			total_snap <= 32'h0;
			dbl_snap   <= 4'h0;
		end
		else
		begin
			total      <= next_total;
			dbl_cnt    <= next_dbl_cnt;
			total_snap <= next_total_snap;
			dbl_snap   <= next_dbl_snap;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// LED: on for lead time before each sample, or throughout the run with debounce
	always @(posedge clk)
	begin
		if (!nrst)
			led_out <= 1'b0;
		else if (running && led_used && (debounce || led_window))
			led_out <= led_pol;
		else
			led_out <= ~led_pol;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Sticky status: an event in the clearing cycle stays set
	reg [2:0]  next_int_stat;
	always @*
	begin
		next_int_stat = int_stat;
		if (do_clr)
			next_int_stat = int_stat & ~wdata[2:0];
		next_int_stat = next_int_stat | events;
	end

	// Register writes, sticky status with set over clear, interrupt
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			shortcut <= 2'b00;
			enable   <= 1'b0;
			led_pol  <= 1'b0;
			interval <= 3'h0;
			rep_per  <= 3'h0;
			psel_led <= `QDR_PSEL_RESET;
			psel_a   <= `QDR_PSEL_RESET;
			psel_b   <= `QDR_PSEL_RESET;
			debounce <= 1'b0;
			led_lead <= 9'h000;
			int_en   <= 3'h0;
			int_stat <= 3'h0;
			irq      <= 1'b0;
		end
		else
		begin
			if (wr)
			begin
				case (addr)
					`QDR_OFS_SHORTCUT: shortcut <= wdata[1:0];
					`QDR_OFS_ENABLE:   enable   <= wdata[0];
					`QDR_OFS_LEDLEVEL: led_pol  <= wdata[0];
					`QDR_OFS_INTERVAL: interval <= wdata[2:0];
					`QDR_OFS_REPPER:   rep_per  <= wdata[2:0];
					`QDR_OFS_LEDPIN:   psel_led <= wdata;
					`QDR_OFS_APIN:     psel_a   <= wdata;
					`QDR_OFS_BPIN:     psel_b   <= wdata;
					`QDR_OFS_DEBOUNCE: debounce <= wdata[0];
					`QDR_OFS_LEDLEAD:  led_lead <= wdata[8:0];
					`QDR_OFS_INTEN:    int_en   <= wdata[2:0];
					default:           ;
				endcase
			end
			int_stat <= next_int_stat;
			irq <= |(int_stat & int_en);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Read port: data one cycle after the strobe, zero otherwise
	reg [31:0] next_rdata;
	always @*
	begin
		next_rdata = 32'h0;
		if (rd)
		begin
			case (addr)
				`QDR_OFS_SHORTCUT: next_rdata = {30'h0, shortcut};
				`QDR_OFS_INTEN:    next_rdata = {29'h0, int_en};
				`QDR_OFS_INTSTAT:  next_rdata = {29'h0, int_stat};
				`QDR_OFS_ENABLE:   next_rdata = {31'h0, enable};
				`QDR_OFS_LEDLEVEL: next_rdata = {31'h0, led_pol};
				`QDR_OFS_INTERVAL: next_rdata = {29'h0, interval};
				`QDR_OFS_STEP:     next_rdata = step;
				`QDR_OFS_REPPER:   next_rdata = {29'h0, rep_per};
				`QDR_OFS_TOTAL:    next_rdata = total;
				`QDR_OFS_TOTSNAP:  next_rdata = total_snap;
				`QDR_OFS_LEDPIN:   next_rdata = psel_led;
				`QDR_OFS_APIN:     next_rdata = psel_a;
				`QDR_OFS_BPIN:     next_rdata = psel_b;
				`QDR_OFS_DEBOUNCE: next_rdata = {31'h0, debounce};
				`QDR_OFS_LEDLEAD:  next_rdata = {23'h0, led_lead};
				`QDR_OFS_DBLCNT:   next_rdata = {28'h0, dbl_cnt};
				`QDR_OFS_DBLSNAP:  next_rdata = {28'h0, dbl_snap};
				default:           next_rdata = 32'h0;
			endcase
		end
	end

	always @(posedge clk)
	begin
		if (!nrst)
			rdata <= 32'h0;
		else
			rdata <= next_rdata;
	end

endmodule // qdr_quad_decoder

// file: qdr_quad_decoder_assertions.sv
// Port-level assertions for the quadrature decoder
`include "qdr_defs.vh"
module qdr_quad_decoder_assertions (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_rd(a);
		rd && addr == a;
	endsequence
	sequence s_mask_off;
		wr && addr == `QDR_OFS_INTEN && wdata == 32'h0 ##1 !(wr && addr == `QDR_OFS_INTEN);
	endsequence
	//////////////////////////////////////////////////////////////////////////////
	a_idle_rdata_zero: assert property (!rd |=> rdata == 32'h0) else $error("rdata not zero");
	a_step_code_set: assert property (s_rd(`QDR_OFS_STEP) |=> rdata inside {0, 1, 2, 32'hffffffff})
		else $error("bad step code");
	a_dbl_count_width: assert property (s_rd(`QDR_OFS_DBLCNT) |=> rdata[31:4] == 0) else $error("count wide");
	a_dbl_snap_width: assert property (s_rd(`QDR_OFS_DBLSNAP) |=> rdata[31:4] == 0) else $error("snap wide");
	a_unmapped_read: assert property (s_rd(12'hffc) |=> rdata == 32'h0) else $error("unmapped not zero");
	a_irq_masked_low: assert property (s_mask_off |=> !irq) else $error("irq while masked");
	a_irq_after_reset: assert property ($rose(nrst) |-> !irq ##1 !irq) else $error("irq after reset");
	a_snap_clears_total: assert property (wr && addr == `QDR_OFS_SNAPCLR ##2 s_rd(`QDR_OFS_TOTAL)
		|=> rdata inside {0, 1, 32'hffffffff}) else $error("total not cleared");
endmodule // qdr_quad_decoder_assertions

bind qdr_quad_decoder qdr_quad_decoder_assertions u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// file: test_quadrature_decoder_regs.sv
// Self-checking bench for the quadrature decoder registers
`include "qdr_defs.vh"
module test_quadrature_decoder_regs;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] mv; logic [31:0] st; logic [31:0] tot;} qdr_row_t;
	logic        clk = 0, nrst = 0, wr = 0, rd = 0, go = 0, led_out, irq;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  move = 2'h0, ph;
	int          n_mismatch = 0, tests_run = 0;
	qdr_row_t    rows [8] = '{'{2'h1, 32'h1, 32'h1}, '{2'h1, 32'h1, 32'h2}, '{2'h2, '1, 32'h1},
		'{2'h3, 32'h2, 32'h1}, '{2'h0, 32'h0, 32'h1}, '{2'h2, '1, 32'h0}, '{2'h2, '1, '1},
		'{2'h2, '1, 32'hfffffffe}};
	qdr_quad_decoder #(.NPINS(32), .BASE_TICKS(4)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pins_in({30'h0, ph[0], ph[1]}), .led_out(led_out), .irq(irq));
	qdr_encoder_model enc (.clk(clk), .go(go), .move(move), .ph(ph));
	always #25 clk = ~clk;
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic summarize;
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		wr_reg(`QDR_OFS_APIN, 32'h0);
		wr_reg(`QDR_OFS_BPIN, 32'h1);
		wr_reg(`QDR_OFS_ENABLE, 32'h1);
		wr_reg(`QDR_OFS_START, 32'h1);
		// First sample only takes the reference
		repeat (5) @(posedge clk);
		foreach (rows[i])
		begin
			move <= rows[i].mv;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			@(posedge clk);
			rd_chk(`QDR_OFS_STEP, rows[i].st);
			rd_chk(`QDR_OFS_TOTAL, rows[i].tot);
			repeat (2) @(posedge clk);
		end
		rd_chk(`QDR_OFS_DBLCNT, 32'h1);
		wr_reg(`QDR_OFS_TOTAL, 32'h5);
		wr_reg(`QDR_OFS_SNAPCLR, 32'h1);
		rd_chk(`QDR_OFS_TOTAL, 32'h0);
		rd_chk(`QDR_OFS_TOTSNAP, 32'hfffffffe);
		rd_chk(`QDR_OFS_DBLSNAP, 32'h1);
		rd_chk(`QDR_OFS_DBLCNT, 32'h0);
		wr_reg(`QDR_OFS_STOP, 32'h1);
		wr_reg(`QDR_OFS_INTEN, 32'h1);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr_reg(`QDR_OFS_INTEN, 32'h0);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		wr_reg(`QDR_OFS_INTCLR, 32'h7);
		rd_chk(`QDR_OFS_INTSTAT, 32'h0);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd_chk(`QDR_OFS_BPIN, `QDR_PSEL_RESET);
		chk({31'h0, led_out}, 32'h1);
		rd_chk(12'hffc, 32'h0);
		summarize();
	end
endmodule // test_quadrature_decoder_regs
